// >>> verilog/cpu_core_pkg.sv
// Shared constants and types for the fetch and execute core
package cpu_core_pkg;

  // --------------------------------------------------------------------
  // Widths and reset values
  // --------------------------------------------------------------------
  localparam int          PC_W         = 23;
  localparam int          INSN_W       = 24;
  localparam int          DATA_W       = 16;
  localparam int          NUM_WREG     = 16;
  localparam logic [3:0]  SP_IDX       = 4'hF;
  localparam logic [22:0] RESET_VECTOR = 23'h000000;
  localparam logic [15:0] SP_RESET     = 16'h0800;
  localparam logic [15:0] WORD_STEP    = 16'h0002;

  // --------------------------------------------------------------------
  // Instruction fields: bit 23 set is a jump, 01 a literal load
  // --------------------------------------------------------------------
  localparam int          JUMP_BIT     = 23;
  localparam logic [1:0]  PFX_LITERAL  = 2'h1;
  localparam logic [1:0]  PFX_GENERAL  = 2'h0;
  localparam logic [5:0]  OP_NOP        = 6'h00;
  localparam logic [5:0]  OP_ADD        = 6'h01;
  localparam logic [5:0]  OP_ADD_MEM    = 6'h02;
  localparam logic [5:0]  OP_MAC        = 6'h03;
  localparam logic [5:0]  OP_DWORD_MOVE = 6'h04;
  localparam logic [5:0]  OP_DO         = 6'h05;
  localparam logic [5:0]  OP_REPEAT     = 6'h06;
  localparam logic [5:0]  OP_CALL       = 6'h07;
  localparam logic [5:0]  OP_RETURN     = 6'h08;
  localparam logic [5:0]  OP_RETFIE     = 6'h09;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN,
    ST_DWORD_HI,
    ST_PUSH_HI,
    ST_POP_LO
  } state_t;

  typedef struct packed {
    logic        we;
    logic [15:0] waddr;
    logic [15:0] wdata;
    logic [15:0] raddr;
  } dm_req_t;

  typedef struct packed {
    logic do_active;
    logic repeat_active;
    logic in_isr;
  } core_status_t;

endpackage : cpu_core_pkg

// >>> verilog/cpu_core.sv
// Fetch and execute control of the 16-bit signal-processing CPU
// Functional notes
// - Program counter is 23 bits, addressing up to 8M 24-bit words.
// - Instruction words are 24 bits with a variable-length opcode field.
// - Next instruction is prefetched one cycle ahead of execution.
// - One cycle per instruction except flow change and double move.
// - Counted block loop and repeat run without overhead; interrupts suspend.
// - Sixteen 16-bit working registers usable as data, pointer or offset.
// - Last working register is the stack pointer for calls and interrupts.
// - One cycle does memory read, register read, memory write and fetch.
// - Controller and signal-processing instructions decode in one core.
`timescale 1ns/1ns
module cpu_core (
  // Clock and master clear
  input  wire logic                       CLK_I,
  input  wire logic                       RST_N_I,
  // Program memory: word for PM_ADDR_O returns on the next cycle
  output logic [cpu_core_pkg::PC_W-1:0]   PM_ADDR_O,
  input  wire logic [cpu_core_pkg::INSN_W-1:0] PM_RDATA_I,
  // Data memory: asynchronous read, write on the clock edge
  output cpu_core_pkg::dm_req_t           DM_REQ_O,
  input  wire logic [cpu_core_pkg::DATA_W-1:0] DM_RDATA_I,
  // Interrupt request from the controller
  input  wire logic                       IRQ_I,
  input  wire logic [cpu_core_pkg::PC_W-1:0] IRQ_VECTOR_I,
  output logic                            IRQ_ACK_O,
  // Loop and service status
  output cpu_core_pkg::core_status_t      STATUS_O
);
  cpu_core_pkg::state_t  state_reg, state_next;
  cpu_core_pkg::dm_req_t dm;
  logic [22:0] fetch_reg, fetch_next, exec_pc_reg, push_pc_reg, rpt_pc_reg;
  logic [22:0] loop_start_reg, loop_end_reg;
  logic [15:0] wreg_reg [0:14];
  logic [15:0] stack_pointer_reg, sp_next;
  logic [15:0] dword_addr_reg, ws_val, wt_val, wd_val, wr_data;
  logic [13:0] rpt_reg;
  logic [7:0]  do_cnt_reg;
  logic [6:0]  pop_hi_reg;
  logic [3:0]  dword_dst_reg, wr_idx;
  logic [5:0]  op;
  logic        squash_reg, squash_next, in_isr_reg, do_active_reg;
  logic        exec_valid, take_irq, run, is_jump, is_lit, is_gen;
  logic        adv, loop_wrap, rpt_hit, wr_en;
  logic signed [31:0] prod;
  function automatic logic [15:0] rd_w(input logic [3:0] idx);
    if (idx == cpu_core_pkg::SP_IDX) rd_w = stack_pointer_reg;
    else rd_w = wreg_reg[idx];
  endfunction : rd_w
  // ----------------------------------------------------------------------
  // Decode, memory ports, next fetch address and stack pointer
  // ----------------------------------------------------------------------
  always_comb begin
    op         = PM_RDATA_I[21:16];
    exec_valid = (state_reg == cpu_core_pkg::ST_RUN) && !squash_reg;
    take_irq   = exec_valid && IRQ_I && !in_isr_reg;
    run        = exec_valid && !take_irq;
    is_jump    = run && PM_RDATA_I[cpu_core_pkg::JUMP_BIT];
    is_lit     = run && PM_RDATA_I[23:22] == cpu_core_pkg::PFX_LITERAL;
    is_gen     = run && PM_RDATA_I[23:22] == cpu_core_pkg::PFX_GENERAL;
    ws_val     = rd_w(PM_RDATA_I[7:4]);
    wt_val     = rd_w(PM_RDATA_I[3:0]);
    wd_val     = rd_w(PM_RDATA_I[11:8]);
    prod       = $signed(ws_val) * $signed(wt_val);
    rpt_hit    = run && rpt_reg != 14'h0000 && exec_pc_reg == rpt_pc_reg;
    loop_wrap  = do_active_reg && fetch_reg == loop_end_reg &&
                 do_cnt_reg != 8'h00;
  end
  always_comb begin
    dm      = '0;
    wr_en   = 1'b0;
    wr_idx  = PM_RDATA_I[11:8];
    wr_data = 16'h0000;
    unique case (state_reg)
      cpu_core_pkg::ST_RUN: begin
        if (take_irq) begin
          dm.we    = 1'b1;
          dm.waddr = stack_pointer_reg;
          dm.wdata = exec_pc_reg[15:0];
        end else if (is_lit) begin
          wr_en   = 1'b1;
          wr_idx  = PM_RDATA_I[19:16];
          wr_data = PM_RDATA_I[15:0];
        end else if (is_gen) begin
          case (op)
            cpu_core_pkg::OP_ADD: begin
              wr_en   = 1'b1;
              wr_data = ws_val + wt_val;
            end
            cpu_core_pkg::OP_ADD_MEM: begin
              dm.raddr = ws_val;
              dm.we    = 1'b1;
              dm.waddr = wd_val;
              dm.wdata = DM_RDATA_I + wt_val;
            end
            cpu_core_pkg::OP_MAC: begin
              wr_en   = 1'b1;
              wr_data = wd_val + prod[30:15];
            end
            cpu_core_pkg::OP_DWORD_MOVE: begin
              dm.raddr = ws_val;
              wr_en    = 1'b1;
              wr_data  = DM_RDATA_I;
            end
            cpu_core_pkg::OP_CALL: begin
              dm.we    = 1'b1;
              dm.waddr = stack_pointer_reg;
              dm.wdata = exec_pc_reg[15:0] + 16'h0001;
            end
            cpu_core_pkg::OP_RETURN, cpu_core_pkg::OP_RETFIE:
              dm.raddr = stack_pointer_reg - cpu_core_pkg::WORD_STEP;
            default: ;
          endcase
        end
      end
      cpu_core_pkg::ST_DWORD_HI: begin
        dm.raddr = dword_addr_reg + cpu_core_pkg::WORD_STEP;
        wr_en    = 1'b1;
        wr_idx   = dword_dst_reg + 4'h1;
        wr_data  = DM_RDATA_I;
      end
      cpu_core_pkg::ST_PUSH_HI: begin
        dm.we    = 1'b1;
        dm.waddr = stack_pointer_reg;
        dm.wdata = {9'h000, push_pc_reg[22:16]};
      end
      cpu_core_pkg::ST_POP_LO:
        dm.raddr = stack_pointer_reg - cpu_core_pkg::WORD_STEP;
    endcase
  end
  assign DM_REQ_O  = dm;
  assign IRQ_ACK_O = take_irq;
  assign PM_ADDR_O = fetch_reg;
  assign STATUS_O  = '{do_active_reg, rpt_reg != 14'h0000, in_isr_reg};
  always_comb begin
    adv         = 1'b1;
    fetch_next  = fetch_reg;
    squash_next = 1'b0;
    state_next  = cpu_core_pkg::ST_RUN;
    sp_next     = stack_pointer_reg;
    if (wr_en && wr_idx == cpu_core_pkg::SP_IDX) sp_next = wr_data;
    if (take_irq) begin
      adv        = 1'b0;
      fetch_next = IRQ_VECTOR_I;
      state_next = cpu_core_pkg::ST_PUSH_HI;
      sp_next    = stack_pointer_reg + cpu_core_pkg::WORD_STEP;
    end else if (is_jump) begin
      adv         = 1'b0;
      fetch_next  = PM_RDATA_I[22:0];
      squash_next = 1'b1;
    end else if (is_gen) begin
      case (op)
        cpu_core_pkg::OP_CALL: begin
          adv        = 1'b0;
          fetch_next = {7'h00, PM_RDATA_I[15:0]};
          state_next = cpu_core_pkg::ST_PUSH_HI;
          sp_next    = stack_pointer_reg + cpu_core_pkg::WORD_STEP;
        end
        cpu_core_pkg::OP_RETURN, cpu_core_pkg::OP_RETFIE: begin
          adv        = 1'b0;
          state_next = cpu_core_pkg::ST_POP_LO;
          sp_next    = stack_pointer_reg - cpu_core_pkg::WORD_STEP;
        end
        cpu_core_pkg::OP_DWORD_MOVE: begin
          adv        = 1'b0;
          state_next = cpu_core_pkg::ST_DWORD_HI;
        end
        cpu_core_pkg::OP_REPEAT:
          adv = PM_RDATA_I[13:0] == 14'h0000;
        default: ;
      endcase
    end
    if (rpt_hit && rpt_reg != 14'h0001) adv = 1'b0;
    if (state_reg == cpu_core_pkg::ST_PUSH_HI)
      sp_next = stack_pointer_reg + cpu_core_pkg::WORD_STEP;
    if (state_reg == cpu_core_pkg::ST_POP_LO) begin
      adv         = 1'b0;
      fetch_next  = {pop_hi_reg, DM_RDATA_I};
      squash_next = 1'b1;
      sp_next     = stack_pointer_reg - cpu_core_pkg::WORD_STEP;
    end
    if (adv) fetch_next = loop_wrap ? loop_start_reg
                                    : fetch_reg + 23'h000001;
  end
  // ----------------------------------------------------------------------
  // Pipeline, loop and working registers
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      fetch_reg   <= cpu_core_pkg::RESET_VECTOR;
      exec_pc_reg <= cpu_core_pkg::RESET_VECTOR;
      squash_reg  <= 1'b1;
      state_reg   <= cpu_core_pkg::ST_RUN;
    end else begin
      fetch_reg   <= fetch_next;
      exec_pc_reg <= fetch_reg;
      squash_reg  <= squash_next;
      state_reg   <= state_next;
    end
  end
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      push_pc_reg    <= '0;
      pop_hi_reg     <= '0;
      dword_addr_reg <= '0;
      dword_dst_reg  <= '0;
      in_isr_reg     <= 1'b0;
    end else begin
      if (take_irq) push_pc_reg <= exec_pc_reg;
      else if (is_gen && op == cpu_core_pkg::OP_CALL)
        push_pc_reg <= exec_pc_reg + 23'h000001;
      if (state_reg == cpu_core_pkg::ST_RUN) pop_hi_reg <= DM_RDATA_I[6:0];
      if (is_gen && op == cpu_core_pkg::OP_DWORD_MOVE) begin
        dword_addr_reg <= ws_val;
        dword_dst_reg  <= PM_RDATA_I[11:8];
      end
      if (take_irq) in_isr_reg <= 1'b1;
      else if (is_gen && op == cpu_core_pkg::OP_RETFIE) in_isr_reg <= 1'b0;
    end
  end
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rpt_reg        <= '0;
      rpt_pc_reg     <= '0;
      do_active_reg  <= 1'b0;
      do_cnt_reg     <= '0;
      loop_start_reg <= '0;
      loop_end_reg   <= '0;
    end else begin
      if (is_gen && op == cpu_core_pkg::OP_REPEAT) begin
        rpt_reg    <= PM_RDATA_I[13:0];
        rpt_pc_reg <= exec_pc_reg + 23'h000001;
      end else if (rpt_hit) rpt_reg <= rpt_reg - 14'h0001;
      if (is_gen && op == cpu_core_pkg::OP_DO) begin
        do_active_reg  <= 1'b1;
        do_cnt_reg     <= PM_RDATA_I[15:8];
        loop_start_reg <= exec_pc_reg + 23'h000001;
        loop_end_reg   <= exec_pc_reg + {15'h0000, PM_RDATA_I[7:0]};
      end else if (adv && do_active_reg && fetch_reg == loop_end_reg) begin
        if (loop_wrap) do_cnt_reg <= do_cnt_reg - 8'h01;
        else do_active_reg <= 1'b0;
      end
    end
  end
  for (genvar i = 0; i < cpu_core_pkg::NUM_WREG - 1; i++) begin : g_wreg
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) wreg_reg[i] <= 16'h0000;
      else if (wr_en && wr_idx == 4'(i)) wreg_reg[i] <= wr_data;
    end
  end
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) stack_pointer_reg <= cpu_core_pkg::SP_RESET;
    else stack_pointer_reg <= sp_next;
  end
  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_jump_idle_cycle: assert property (is_jump |=> squash_reg &&
      PM_ADDR_O == $past(PM_RDATA_I[22:0])) else $error("jump target lost");
  a_prefetch_step: assert property (state_reg == cpu_core_pkg::ST_RUN &&
      squash_reg && !loop_wrap |=> PM_ADDR_O == $past(PM_ADDR_O) + 23'h1)
      else $error("prefetch did not advance");
  a_add_one_cycle: assert property (is_gen && op == cpu_core_pkg::OP_ADD
      |=> state_reg == cpu_core_pkg::ST_RUN && !squash_reg)
      else $error("add took extra cycle");
  a_dword_two_cycles: assert property (
      is_gen && op == cpu_core_pkg::OP_DWORD_MOVE |=>
      state_reg == cpu_core_pkg::ST_DWORD_HI ##1
      state_reg == cpu_core_pkg::ST_RUN) else $error("double move timing");
  a_repeat_hold: assert property (is_gen && op == cpu_core_pkg::OP_REPEAT
      && PM_RDATA_I[13:0] != 14'h0 |=> $stable(PM_ADDR_O))
      else $error("repeat did not hold fetch");
  a_irq_vector: assert property (take_irq |=>
      PM_ADDR_O == $past(IRQ_VECTOR_I) && STATUS_O.in_isr)
      else $error("interrupt vector not fetched");
  a_stack_push: assert property (take_irq |-> DM_REQ_O.we &&
      DM_REQ_O.waddr == stack_pointer_reg ##1
      stack_pointer_reg == $past(stack_pointer_reg) + 16'h2 ##1
      stack_pointer_reg == $past(stack_pointer_reg, 2) + 16'h4)
      else $error("context push wrong");
  a_three_operand: assert property (is_gen &&
      op == cpu_core_pkg::OP_ADD_MEM |-> DM_REQ_O.we &&
      DM_REQ_O.waddr == wd_val && DM_REQ_O.wdata == DM_RDATA_I + wt_val)
      else $error("memory add wrong");
  a_literal_write: assert property (is_lit &&
      PM_RDATA_I[19:16] != cpu_core_pkg::SP_IDX |=>
      rd_w($past(PM_RDATA_I[19:16])) == $past(PM_RDATA_I[15:0]))
      else $error("literal not written");
  c_irq_taken: cover property (take_irq ##2 exec_valid);
  c_repeat_run: cover property (rpt_hit ##1 rpt_hit ##1 rpt_hit);
  c_loop_wrap: cover property (adv && loop_wrap);
  c_return: cover property (state_reg == cpu_core_pkg::ST_POP_LO ##2 exec_valid);
endmodule : cpu_core

// >>> verification/cpu_mem_model.sv
// Program and data memory partner of the fetch and execute core
`timescale 1ns/1ns
module cpu_mem_model (
  // Clock
  input  wire logic                  clk_i,
  // Program memory port
  input  wire logic [22:0]           pm_addr_i,
  output logic [23:0]                pm_rdata_o,
  // Data memory port
  input  wire cpu_core_pkg::dm_req_t dm_req_i,
  output logic [15:0]                dm_rdata_o
);
  // --------------------
  // Storage, loaded by the bench
  // --------------------
  logic [23:0] pmem [128];
  logic [15:0] dmem [32768];

  // Word for the address of the previous cycle; upper address bits alias
  always @(posedge clk_i) begin
    pm_rdata_o <= pmem[pm_addr_i[6:0]];
  end

  assign dm_rdata_o = dmem[dm_req_i.raddr[15:1]];

  always @(posedge clk_i) begin
    if (dm_req_i.we === 1'b1) begin
      dmem[dm_req_i.waddr[15:1]] <= dm_req_i.wdata;
    end
  end
endmodule : cpu_mem_model

// >>> verification/dsc_cpu_fetch_execute_core_tb_top.sv
// Self-checking bench for the fetch and execute core
`timescale 1ns/1ns
module dsc_cpu_fetch_execute_core_tb_top;
  typedef struct {
    int a;
    int d;
    int g;
  } exp_t;

  // --------------------
  // Signals and model state
  // --------------------
  logic                       clk;
  logic                       rst_n;
  logic [22:0]                pm_addr;
  logic [23:0]                pm_rdata;
  cpu_core_pkg::dm_req_t      dm_req;
  logic [15:0]                dm_rdata;
  logic                       irq;
  logic [22:0]                irq_vec;
  logic                       irq_ack;
  cpu_core_pkg::core_status_t status;
  int                         fail_count = 0;
  int                         n_tests = 0;
  int                         cyc = 0;
  int                         last = 0;
  int                         w [16];
  int                         dm [32768];
  exp_t                       exp_q [$];

  cpu_core i_cpu_core (
    .CLK_I        (clk),
    .RST_N_I      (rst_n),
    .PM_ADDR_O    (pm_addr),
    .PM_RDATA_I   (pm_rdata),
    .DM_REQ_O     (dm_req),
    .DM_RDATA_I   (dm_rdata),
    .IRQ_I        (irq),
    .IRQ_VECTOR_I (irq_vec),
    .IRQ_ACK_O    (irq_ack),
    .STATUS_O     (status)
  );

  cpu_mem_model i_cpu_mem_model (
    .clk_i      (clk),
    .pm_addr_i  (pm_addr),
    .pm_rdata_o (pm_rdata),
    .dm_req_i   (dm_req),
    .dm_rdata_o (dm_rdata)
  );

  always #5 clk = ~clk;

  // --------------------
  // Checking and program assembly
  // --------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
      fail_count++;
    end
  endtask : chk

  task automatic wrap_up();
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic wait_empty();
    int k;
    k = 0;
    while (exp_q.size() != 0 && k < 300) begin
      @(posedge clk);
      k++;
    end
    if (exp_q.size() != 0) begin
      chk("write timeout", 32'h0, 32'h1);
      wrap_up();
    end
  endtask : wait_empty

  function automatic int op(input logic [5:0] o, input int d, s, t);
    return {8'h00, 2'b00, o, 4'h0, d[3:0], s[3:0], t[3:0]};
  endfunction : op

  function automatic int mac(input int a, input int b);
    logic signed [15:0] x;
    logic signed [15:0] y;
    int p;
    x = a[15:0];
    y = b[15:0];
    p = x * y;
    return (p >> 15) & 32'h0000FFFF;
  endfunction : mac

  task automatic put(input int a, input int x);
    i_cpu_mem_model.pmem[a] = x[23:0];
  endtask : put

  task automatic lit(input int a, input int d, input int v);
    put(a, {8'h00, 4'h4, d[3:0], v[15:0]});
    w[d] = v & 32'h0000FFFF;
  endtask : lit

  // Expected write of a memory add: [Wd] = [Ws] + Wt, g cycles after the last
  task automatic madd(input int d, s, t, g);
    int v;
    v = (dm[w[s] >> 1] + w[t]) & 32'h0000FFFF;
    exp_q.push_back('{w[d], v, g});
    dm[w[d] >> 1] = v;
  endtask : madd

  task automatic push(input int pc, input int g);
    exp_q.push_back('{w[15], pc & 32'h0000FFFF, g});
    exp_q.push_back('{w[15] + 2, (pc >> 16) & 32'h0000007F, 1});
  endtask : push

  always @(posedge clk) begin
    exp_t e;
    if (rst_n === 1'b1) begin
      cyc++;
      if (dm_req.we === 1'b1) begin
        if (exp_q.size() == 0) begin
          chk("stray write", 32'h0, 32'h1);
        end else begin
          e = exp_q.pop_front();
          chk("write address", e.a, dm_req.waddr);
          chk("write data", e.d, dm_req.wdata);
          if (e.g >= 0) chk("write spacing", e.g, cyc - last);
          last = cyc;
        end
      end
    end
  end

  // --------------------
  // Main sequence
  // --------------------
  initial begin
    int k;
    k = $urandom(74685);
    clk = 1'b0;
    rst_n = 1'b0;
    irq = 1'b0;
    irq_vec = 23'h000040;
    for (int i = 0; i < 128; i++) put(i, 0);
    for (int i = 0; i < 32768; i++) begin
      i_cpu_mem_model.dmem[i] = 16'h0000;
      dm[i] = 0;
    end
    for (int i = 0; i < 16; i++) w[i] = 0;
    w[15] = int'(cpu_core_pkg::SP_RESET);
    dm[128] = $urandom_range(0, 65535);
    dm[129] = $urandom_range(0, 65535);
    i_cpu_mem_model.dmem[128] = dm[128][15:0];
    i_cpu_mem_model.dmem[129] = dm[129][15:0];
    lit(0, 1, 32'h0100);
    lit(1, 2, $urandom_range(0, 65535));
    lit(2, 3, 32'h0200);
    put(3, op(cpu_core_pkg::OP_ADD_MEM, 3, 1, 2));
    madd(3, 1, 2, -1);
    put(4, op(cpu_core_pkg::OP_REPEAT, 0, 0, 3));
    put(5, op(cpu_core_pkg::OP_ADD_MEM, 3, 3, 2));
    madd(3, 3, 2, 2);
    repeat (3) madd(3, 3, 2, 1);
    put(6, op(cpu_core_pkg::OP_DO, 2, 0, 2));
    put(7, op(cpu_core_pkg::OP_ADD_MEM, 3, 3, 2));
    put(8, op(cpu_core_pkg::OP_ADD, 6, 6, 2));
    repeat (3) begin
      madd(3, 3, 2, 2);
      w[6] = (w[6] + w[2]) & 32'h0000FFFF;
    end
    put(9, op(cpu_core_pkg::OP_CALL, 0, 2, 0));
    push(10, 2);
    put(32'h20, op(cpu_core_pkg::OP_ADD_MEM, 1, 3, 2));
    madd(1, 3, 2, 1);
    put(32'h21, op(cpu_core_pkg::OP_RETURN, 0, 0, 0));
    put(10, 32'h00C00030);
    put(32'h30, op(cpu_core_pkg::OP_DWORD_MOVE, 4, 1, 0));
    w[4] = dm[w[1] >> 1];
    w[5] = dm[(w[1] >> 1) + 1];
    put(32'h31, op(cpu_core_pkg::OP_ADD_MEM, 3, 3, 4));
    madd(3, 3, 4, -1);
    put(32'h32, op(cpu_core_pkg::OP_ADD_MEM, 3, 3, 5));
    madd(3, 3, 5, 1);
    put(32'h33, op(cpu_core_pkg::OP_MAC, 6, 2, 4));
    w[6] = (w[6] + mac(w[2], w[4])) & 32'h0000FFFF;
    put(32'h34, op(cpu_core_pkg::OP_ADD_MEM, 3, 3, 6));
    madd(3, 3, 6, 2);
    put(32'h35, 32'h00C00035);
    put(32'h40, op(cpu_core_pkg::OP_ADD_MEM, 1, 1, 2));
    put(32'h41, op(cpu_core_pkg::OP_RETFIE, 0, 0, 0));
    repeat (2) @(posedge clk);
    #1 chk("reset address", 32'h0, pm_addr);
    chk("reset status", 32'h0, status);
    rst_n = 1'b1;
    @(posedge clk);
    #1 chk("first fetch", 32'h1, pm_addr);
    wait_empty();
    repeat ($urandom_range(1, 6)) @(posedge clk);
    push(32'h400035, -1);
    madd(1, 1, 2, 1);
    #1 irq = 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (irq_ack !== 1'b1 && k < 50);
    chk("ack wait", 32'h1, irq_ack);
    if (irq_ack !== 1'b1) wrap_up();
    #1 chk("vector fetch", 32'h40, pm_addr);
    chk("service flag", 32'h1, status.in_isr);
    repeat (2) begin
      @(posedge clk);
      chk("ack pulse", 32'h0, irq_ack);
    end
    #1 irq = 1'b0;
    wait_empty();
    k = 0;
    while (status.in_isr !== 1'b0 && k < 20) begin
      @(posedge clk);
      k++;
    end
    chk("service end", 32'h0, status.in_isr);
    if (status.in_isr !== 1'b0) wrap_up();
    repeat (4) @(posedge clk);
    chk("idle status", 32'h0, status);
    chk("pending writes", 32'h0, exp_q.size());
    #1 rst_n = 1'b0;
    #1 chk("clear address", 32'h0, pm_addr);
    chk("clear write", 32'h0, dm_req.we);
    wrap_up();
  end
endmodule : dsc_cpu_fetch_execute_core_tb_top
